/* pkg/bpp_cfg.svh */
`ifndef BPP_CFG_SVH
`define BPP_CFG_SVH

// Register offsets: first port at base, second port one block above
`define BPP_PORT_STRIDE   12'h100
`define BPP_OFS_DATA      12'h000
`define BPP_OFS_OE        12'h004
`define BPP_OFS_FSEL      12'h008
`define BPP_OFS_OD        12'h028
`define BPP_OFS_PUP       12'h02C
`define BPP_OFS_IE        12'h038
`define BPP_ADDR_BITS     12
// Address bit that picks the port block, and the end of the mapped span
`define BPP_PORT_SEL_BIT  8
`define BPP_ADDR_SPAN     12'h200
`define BPP_PIN_RESET     8'h00
`define BPP_PORT_BITS     8

`endif

/* pkg/bpp_pkg.sv */
package bpp_pkg;

    // Per-pin controls of one port
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] oe;
        logic [7:0] fsel;
        logic [7:0] od;
        logic [7:0] pup;
        logic [7:0] ie;
    } bpp_port_cfg_t;

    // Pad-side drive of one port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pup;
        logic [7:0] ie;
    } bpp_pad_drv_t;

    // Register selected by an access
    typedef enum logic [2:0] {
        BPP_REG_DATA,
        BPP_REG_OE,
        BPP_REG_FSEL,
        BPP_REG_OD,
        BPP_REG_PUP,
        BPP_REG_IE,
        BPP_REG_NONE
    } bpp_reg_t;

endpackage

/* verilog/bpp_pin_mux.sv */
`timescale 1ns/100ps
`default_nettype none

module bpp_pin_mux
    import bpp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Port configuration
    input  wire bpp_port_cfg_t cfg,
    // External bus controller side
    input  wire logic [WIDTH-1:0] bus_out,
    input  wire logic [WIDTH-1:0] bus_oe,
    // Pad input and resulting drive
    input  wire logic [WIDTH-1:0] pad_in,
    output var bpp_pad_drv_t      drv,
    output logic [WIDTH-1:0]      pin_in
);

    logic [WIDTH-1:0] val;
    logic [WIDTH-1:0] en;

    always_comb begin
        // Bus controller takes over selected pins
        val = (cfg.fsel & bus_out) | (~cfg.fsel & cfg.data);
        en  = (cfg.fsel & bus_oe) | (~cfg.fsel & cfg.oe);
        // Open drain: drive only when value is low
        drv.oe  = en & ~(cfg.od & val);
        drv.out = val & ~cfg.od;
        drv.pup = cfg.pup;
        drv.ie  = cfg.ie;
        pin_in  = pad_in & cfg.ie;
    end

endmodule // bpp_pin_mux

`default_nettype wire

/* verilog/bpp_port_pair.sv */
// Notes on behaviour
// - Each port has eight pins, each bit configured on its own.
// - Reset makes every pin general purpose, input, output and pull-up off.
// - Function-select 0 gives pin to port I/O, 1 to alternate function.
// - First port bit n carries external bus data/address bit n when selected.
// - Second port can also serve the external bus through its alternate function.
// - Open-drain bit 0 gives push-pull, 1 gives low-only drive.
// - Pull-up bit 1 enables internal pull-up, 0 disables it.
// - Input bit 1 enables the input path, 0 disables it.
// - Second port registers at 0x0, 0x4, 0x8, 0x28, 0x2C, 0x38 from its base.
// - Bits 7..0 read/write; bits 31..8 read as zero.
// - Second port bit n carries external bus bit n+8 when selected.
// - Output-enable bit 1 enables the driver, 0 disables it.
`timescale 1ns/100ps
`default_nettype none
`include "bpp_cfg.svh"

module bpp_port_pair
    import bpp_pkg::*;
#(
    parameter int PORTS = 2
) (
    // System
    input  wire logic        clock,
    input  wire logic        nrst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // External bus controller, 16 bits
    input  wire logic [15:0] ext_bus_data_out,
    input  wire logic [15:0] ext_bus_data_oe,
    output logic [15:0]      ext_bus_data_in,
    // Pads: first port in low byte, second in high byte
    input  wire logic [15:0] pad_in,
    output logic [15:0]      pad_out,
    output logic [15:0]      pad_oe,
    output logic [15:0]      pad_pullup,
    output logic [15:0]      pad_in_en
);

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    bpp_port_cfg_t cfg_q [PORTS];
    logic          ack_q;
    logic [31:0]   rdat_q;
    logic [15:0]   pin_in;
    bpp_pad_drv_t  drv [PORTS];

    function automatic bpp_reg_t decode(input logic [11:0] adr);
        logic [11:0] ofs;
        ofs = adr & (`BPP_PORT_STRIDE - 12'h001);
        case (ofs)
            `BPP_OFS_DATA: decode = BPP_REG_DATA;
            `BPP_OFS_OE:   decode = BPP_REG_OE;
            `BPP_OFS_FSEL: decode = BPP_REG_FSEL;
            `BPP_OFS_OD:   decode = BPP_REG_OD;
            `BPP_OFS_PUP:  decode = BPP_REG_PUP;
            `BPP_OFS_IE:   decode = BPP_REG_IE;
            default:       decode = BPP_REG_NONE;
        endcase
    endfunction

    function automatic logic port_idx(input logic [11:0] adr);
        port_idx = adr[`BPP_PORT_SEL_BIT];
    endfunction

    logic     req;
    bpp_reg_t rsel;
    logic     pidx;
    logic     in_range;

    always_comb begin
        req      = wb_cyc_i && wb_stb_i && !ack_q;
        rsel     = decode(wb_adr_i);
        pidx     = port_idx(wb_adr_i);
        // Only two port blocks exist; higher blocks are unmapped
        in_range = (wb_adr_i < `BPP_ADDR_SPAN);
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait state, ack for one cycle

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int p = 0; p < PORTS; p++) begin
                cfg_q[p] <= '{default: `BPP_PIN_RESET};
            end
        end else if (req && wb_we_i && wb_sel_i[0] && in_range) begin
            case (rsel)
                BPP_REG_DATA: cfg_q[pidx].data <= wb_dat_i[7:0];
                BPP_REG_OE:   cfg_q[pidx].oe   <= wb_dat_i[7:0];
                BPP_REG_FSEL: cfg_q[pidx].fsel <= wb_dat_i[7:0];
                BPP_REG_OD:   cfg_q[pidx].od   <= wb_dat_i[7:0];
                BPP_REG_PUP:  cfg_q[pidx].pup  <= wb_dat_i[7:0];
                BPP_REG_IE:   cfg_q[pidx].ie   <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data; unmapped addresses read zero but still ack

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdat_q <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            rdat_q <= 32'h0000_0000;
            if (in_range) begin
                case (rsel)
                    BPP_REG_DATA: rdat_q[7:0] <= pidx ? pin_in[15:8] : pin_in[7:0];
                    BPP_REG_OE:   rdat_q[7:0] <= cfg_q[pidx].oe;
                    BPP_REG_FSEL: rdat_q[7:0] <= cfg_q[pidx].fsel;
                    BPP_REG_OD:   rdat_q[7:0] <= cfg_q[pidx].od;
                    BPP_REG_PUP:  rdat_q[7:0] <= cfg_q[pidx].pup;
                    BPP_REG_IE:   rdat_q[7:0] <= cfg_q[pidx].ie;
                    default: ;
                endcase
            end
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin muxing: port 0 carries bus bits 7..0, port 1 bits 15..8

    for (genvar p = 0; p < PORTS; p++) begin : g_port
        bpp_pin_mux #(
            .WIDTH (`BPP_PORT_BITS)
        ) u_mux (
            .cfg     (cfg_q[p]),
            .bus_out (ext_bus_data_out[p*8 +: 8]),
            .bus_oe  (ext_bus_data_oe[p*8 +: 8]),
            .pad_in  (pad_in[p*8 +: 8]),
            .drv     (drv[p]),
            .pin_in  (pin_in[p*8 +: 8])
        );
    end

    // Registered pad drive so every output comes from a flop
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pad_out         <= 16'h0000;
            pad_oe          <= 16'h0000;
            pad_pullup      <= 16'h0000;
            pad_in_en       <= 16'h0000;
            ext_bus_data_in <= 16'h0000;
        end else begin
            pad_out         <= {drv[1].out, drv[0].out};
            pad_oe          <= {drv[1].oe, drv[0].oe};
            pad_pullup      <= {drv[1].pup, drv[0].pup};
            pad_in_en       <= {drv[1].ie, drv[0].ie};
            // Bus sees the pin only where the function and input are enabled
            ext_bus_data_in <= pin_in & {cfg_q[1].fsel, cfg_q[0].fsel};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Bus handshake and register access
    chk_ack_one_cycle: assert property (@(posedge clock) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");

    chk_ack_after_req: assert property (@(posedge clock) disable iff (!nrst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("no ack after request");

    chk_upper_zero: assert property (@(posedge clock) disable iff (!nrst)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper read bits nonzero");

    chk_unmapped_zero: assert property (@(posedge clock) disable iff (!nrst)
        (wb_ack_o && !wb_we_i && !$past(in_range)) |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read nonzero");

    chk_fsel_read: assert property (@(posedge clock) disable iff (!nrst)
        (wb_ack_o && !wb_we_i && $past(rsel) == BPP_REG_FSEL && $past(in_range))
        |-> wb_dat_o[7:0] == $past(pidx ? cfg_q[1].fsel : cfg_q[0].fsel)) else $error("fsel readback wrong");

    chk_write_lands: assert property (@(posedge clock) disable iff (!nrst)
        (req && wb_we_i && wb_sel_i[0] && in_range && rsel == BPP_REG_DATA && !pidx)
        |=> cfg_q[0].data == $past(wb_dat_i[7:0])) else $error("data write lost");

    ////////////////////////////////////////////////////////////////////////
    // Reset and input path

    chk_reset_quiet: assert property (@(posedge clock)
        !nrst |=> (pad_oe == 16'h0000 && pad_pullup == 16'h0000 && pad_in_en == 16'h0000))
        else $error("pins active after reset");

    chk_ie_gate: assert property (@(posedge clock) disable iff (!nrst)
        (wb_ack_o && !wb_we_i && $past(rsel) == BPP_REG_DATA && $past(in_range) && !$past(pidx))
        |-> (wb_dat_o[7:0] & ~cfg_q[0].ie) == 8'h00) else $error("disabled input read nonzero");

    chk_ie_gate_hi: assert property (@(posedge clock) disable iff (!nrst)
        (wb_ack_o && !wb_we_i && $past(rsel) == BPP_REG_DATA && $past(in_range) && $past(pidx))
        |-> (wb_dat_o[7:0] & ~cfg_q[1].ie) == 8'h00) else $error("disabled input read nonzero");

    chk_ie_follow: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> pad_in_en == {$past(cfg_q[1].ie), $past(cfg_q[0].ie)})
        else $error("input enable not following control");

    chk_pup_follow: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> pad_pullup == {$past(cfg_q[1].pup), $past(cfg_q[0].pup)})
        else $error("pull-up not following control");

    // The bus controller only ever sees pins that are both selected and enabled
    chk_ext_in_gate: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> ext_bus_data_in == $past(pad_in & {cfg_q[1].ie, cfg_q[0].ie} & {cfg_q[1].fsel, cfg_q[0].fsel}))
        else $error("bus input not gated");

    ////////////////////////////////////////////////////////////////////////
    // Drive path

    chk_od_no_high: assert property (@(posedge clock) disable iff (!nrst)
        (cfg_q[0].od[0] && $stable(cfg_q[0].od[0])) |=> !(pad_oe[0] && pad_out[0]))
        else $error("open drain drove high");

    chk_pushpull_high: assert property (@(posedge clock) disable iff (!nrst)
        (!cfg_q[0].od[3] && !cfg_q[0].fsel[3] && cfg_q[0].oe[3] && cfg_q[0].data[3])
        |=> (pad_oe[3] && pad_out[3])) else $error("push-pull did not drive high");

    chk_bus_takeover: assert property (@(posedge clock) disable iff (!nrst)
        (cfg_q[1].fsel[0] && !cfg_q[1].od[0]) |=> pad_oe[8] == $past(ext_bus_data_oe[8]))
        else $error("bus enable not on second port pin");

    chk_bus_value_hi: assert property (@(posedge clock) disable iff (!nrst)
        (cfg_q[1].fsel[7] && !cfg_q[1].od[7] && ext_bus_data_oe[15])
        |=> pad_out[15] == $past(ext_bus_data_out[15])) else $error("bus bit 15 not on second port");

    chk_bus_value_lo: assert property (@(posedge clock) disable iff (!nrst)
        (cfg_q[0].fsel[0] && !cfg_q[0].od[0] && ext_bus_data_oe[0])
        |=> pad_out[0] == $past(ext_bus_data_out[0])) else $error("bus bit 0 not on first port");

    chk_gpio_value: assert property (@(posedge clock) disable iff (!nrst)
        (!cfg_q[0].fsel[2] && !cfg_q[0].od[2]) |=> pad_out[2] == $past(cfg_q[0].data[2]))
        else $error("port latch not on pin");

    chk_gpio_oe: assert property (@(posedge clock) disable iff (!nrst)
        (!cfg_q[0].fsel[1] && !cfg_q[0].od[1]) |=> pad_oe[1] == $past(cfg_q[0].oe[1]))
        else $error("port output enable not applied");

    chk_gpio_oe_hi: assert property (@(posedge clock) disable iff (!nrst)
        (!cfg_q[1].fsel[5] && !cfg_q[1].od[5]) |=> pad_oe[13] == $past(cfg_q[1].oe[5]))
        else $error("second port output enable not applied");

endmodule // bpp_port_pair

`default_nettype wire

/* verification/bpp_pad_model.sv */
`timescale 1ns/100ps
`default_nettype none

module bpp_pad_model (
    // Clock for the idle pattern
    input  wire logic        clock,
    // Pad side of the block
    input  wire logic [15:0] pad_out,
    input  wire logic [15:0] pad_oe,
    input  wire logic [15:0] pad_pullup,
    // Bus device on the far side
    input  wire logic [15:0] ext_val,
    input  wire logic [15:0] ext_oe,
    output logic [15:0]      pad_in
);
    logic [15:0] float_q = 16'h0000;

    // Released pins without pull-up toggle, so a stale level never passes for data
    always @(posedge clock) float_q <= ~float_q;

    // Block wins a clash; a pull-up only shows on a pin nobody drives
    always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
                       | (~pad_oe & ~ext_oe & (pad_pullup | float_q));
endmodule // bpp_pad_model

`default_nettype wire

/* verification/bpp_port_pair_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bpp_cfg.svh"

module bpp_port_pair_tb_top;
    logic        clock = 1'b0, nrst = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [15:0] bo = 16'h0, be = 16'h0, ev = 16'h0, eo = 16'hFFFF, pad_in;
    logic [15:0] ext_bus_data_in, pad_out, pad_oe, pad_pullup, pad_in_en;
    logic [11:0] ofs[6] = '{`BPP_OFS_DATA, `BPP_OFS_OE, `BPP_OFS_FSEL, `BPP_OFS_OD, `BPP_OFS_PUP, `BPP_OFS_IE};
    logic [31:0] expq[$];
    int          num_errors = 0, n_compared = 0;

    always #25 clock = ~clock;

    bpp_port_pair i_dut (.clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ext_bus_data_out(bo), .ext_bus_data_oe(be), .ext_bus_data_in(ext_bus_data_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pad_in_en(pad_in_en));
    bpp_pad_model i_pads (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .ext_val(ev), .ext_oe(eo), .pad_in(pad_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Entered just after a rising edge; holds the request until ack is seen, giving up after 21 rising edges
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clock); while (wb_ack_o !== 1'b1 && n++ < 20);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        wb(1'b0, a, 32'h0);
    endtask

    always @(posedge clock) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) cmp(wb_dat_o, expq.pop_front());
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] oe, fs, od, pu, ie, d, oe_e, pin;
        logic [15:0] rv[6];
        logic [31:0] v;
        logic [11:0] a;
        v = $urandom(32'h3E1234D2);
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        cmp({pad_out, pad_oe}, 32'h0);
        cmp({pad_pullup, pad_in_en}, 32'h0);
        for (int p = 0; p < 2; p++)
            for (int r = 0; r < 6; r++) rd((p ? `BPP_PORT_STRIDE : 12'h000) + ofs[r], 32'h0);
        for (int p = 0; p < 2; p++)
            for (int r = 1; r < 6; r++) begin
                a = (p ? `BPP_PORT_STRIDE : 12'h000) + ofs[r];
                v = $urandom;
                wb(1'b1, a, v);
                rd(a, {24'h0, v[7:0]});
            end
        rd(12'h010, 32'h0);
        wb(1'b1, 12'h200, 32'hFF);
        rd(12'h200, 32'h0);
        for (int i = 0; i < 8; i++) begin
            {oe, fs, od, pu, ie, d} = {$urandom, $urandom, $urandom};
            if (i[0]) od = 16'h0;
            else fs = 16'h0;
            oe = oe | fs;
            ie = ie | fs;
            {bo, be, ev} <= {$urandom, 16'($urandom)};
            rv = '{d, oe, fs, od, pu, ie};
            for (int p = 0; p < 2; p++)
                for (int r = 0; r < 6; r++) wb(1'b1, (p ? `BPP_PORT_STRIDE : 12'h000) + ofs[r], {24'h0, rv[r][p*8 +: 8]});
            repeat (2) @(posedge clock);
            #1;
            oe_e = (fs & be) | (~fs & oe & ~(od & d));
            pin = (oe_e & ((fs & bo) | (~fs & d & ~od))) | (~oe_e & ev);
            cmp({pad_oe, pad_out & pad_oe}, {oe_e, pin & oe_e});
            cmp({pad_pullup, pad_in_en}, {pu, ie});
            cmp({16'h0, ext_bus_data_in}, {16'h0, pin & ie & fs});
            @(posedge clock);
            v = {16'h0, pin & ie};
            rd(12'h000, {24'h0, v[7:0]});
            rd(`BPP_PORT_STRIDE, {24'h0, v[15:8]});
        end
        // Reset in mid-run must clear every control again
        nrst <= 1'b0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        cmp({pad_oe, pad_pullup}, 32'h0);
        cmp({pad_in_en, ext_bus_data_in}, 32'h0);
        rd(`BPP_OFS_FSEL, 32'h0);
        rd(`BPP_PORT_STRIDE + `BPP_OFS_IE, 32'h0);
        print_verdict();
    end

    // About 500 cycles suffice; wb gives up a hung handshake itself, this stops any other stall
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        print_verdict();
    end
endmodule // bpp_port_pair_tb_top

`default_nettype wire
